// File: design/xfd_pkg.sv
// Constants, types and helpers for the floating-point decode latency block
package xfd_pkg;

  // ----------------------------------------------------------------
  // Opcode bytes and ModR/M fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_0F = 8'h0f;
  localparam logic [7:0] OPC_AE = 8'hae;
  localparam logic [7:0] OPC_9B = 8'h9b;
  localparam logic [7:0] OPC_D8 = 8'hd8;
  localparam logic [7:0] OPC_D9 = 8'hd9;
  localparam logic [7:0] OPC_DA = 8'hda;
  localparam logic [7:0] OPC_DB = 8'hdb;
  localparam logic [7:0] OPC_DC = 8'hdc;
  localparam logic [7:0] OPC_DD = 8'hdd;
  localparam logic [7:0] OPC_DE = 8'hde;
  localparam logic [7:0] OPC_DF = 8'hdf;

  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] F_000   = 3'h0;
  localparam logic [2:0] F_001   = 3'h1;
  localparam logic [2:0] F_010   = 3'h2;
  localparam logic [2:0] F_100   = 3'h4;
  localparam logic [2:0] F_101   = 3'h5;
  localparam logic [2:0] F_110   = 3'h6;
  localparam logic [2:0] F_111   = 3'h7;

  // ----------------------------------------------------------------
  // Pipes, precision and latencies
  // ----------------------------------------------------------------
  localparam logic [2:0] PIPE_NONE  = 3'h0;
  localparam logic [2:0] PIPE_ADD   = 3'h1;
  localparam logic [2:0] PIPE_MUL   = 3'h2;
  localparam logic [2:0] PIPE_ANY   = 3'h7;
  localparam int         NUM_PIPES  = 3;

  localparam logic [1:0] PC_SINGLE  = 2'h0;
  localparam logic [1:0] PC_DOUBLE  = 2'h2;

  localparam logic [7:0] LAT_NONE   = 8'h00;
  localparam logic [7:0] LAT_NOP    = 8'h02;
  localparam logic [7:0] LAT_CMP    = 8'h02;
  localparam logic [7:0] LAT_XCH    = 8'h02;
  localparam logic [7:0] LAT_UCOMI  = 8'h03;
  localparam logic [7:0] LAT_XAM    = 8'h03;
  localparam logic [7:0] LAT_SUB    = 8'h04;
  localparam logic [7:0] LAT_XTRACT = 8'h07;
  localparam logic [7:0] LAT_REM    = 8'h09;
  localparam logic [7:0] LAT_SQRT_S = 8'h13;
  localparam logic [7:0] LAT_SQRT_D = 8'h1b;
  localparam logic [7:0] LAT_SQRT_E = 8'h23;
  localparam logic [7:0] LAT_RST_LO = 8'h44;
  localparam logic [7:0] LAT_RST_HI = 8'h6c;
  localparam logic [7:0] LAT_SAV_LO = 8'h1f;
  localparam logic [7:0] LAT_SAV_HI = 8'h4f;
  localparam logic [7:0] LAT_LOG_LO = 8'h74;
  localparam logic [7:0] LAT_LOG_HI = 8'h7e;
  localparam logic [7:0] LAT_LOGP1  = 8'h7e;
  localparam logic [7:0] REM_N_MAX  = 8'h20;

  // ----------------------------------------------------------------
  // Table entry types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_FIX  = 3'b000,
    LK_RNG  = 3'b001,
    LK_PAIR = 3'b011,
    LK_PREC = 3'b010,
    LK_REM  = 3'b110
  } xfd_lat_type;

  typedef struct packed {
    logic        known;
    logic        micro;
    logic        single;
    logic [2:0]  pipes;
    logic        nop_gen;
    logic        best;
    xfd_lat_type kind;
    logic [7:0]  lat_a;
    logic [7:0]  lat_b;
    logic [7:0]  lat_c;
  } xfd_ent_type;

  localparam xfd_ent_type ENT_NONE = '0;

  function automatic xfd_ent_type xfd_mk(
    input logic        micro,
    input logic        single,
    input logic [2:0]  pipes,
    input logic        nop_gen,
    input xfd_lat_type kind,
    input logic [7:0]  a,
    input logic [7:0]  b,
    input logic [7:0]  c
  );
    xfd_ent_type e;
    e = '{1'b1, micro, single, pipes, nop_gen, 1'b0, kind, a, b, c};
    return e;
  endfunction : xfd_mk

endpackage : xfd_pkg

// File: design/xfd_ent_if.sv
// Carrier for one registered decode-table entry
`timescale 1ns/1ps
interface xfd_ent_if;
  import xfd_pkg::*;
  xfd_ent_type ent;
  modport src (output ent);
  modport snk (input  ent);
endinterface : xfd_ent_if

// File: design/xfd_table.sv
// Decode table lookup with registered entry output
`timescale 1ns/1ps
module xfd_table
  import xfd_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_opc0,
  input  wire logic [7:0] i_opc1,
  input  wire logic [7:0] i_modrm,
  xfd_ent_if.src          ent_if
);

  logic        rf;
  logic [2:0]  fr;
  logic [2:0]  fm;
  xfd_ent_type e_nxt;
  xfd_ent_type add4;
  xfd_ent_type cmp2;

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  always_comb
  begin
    rf    = (i_modrm[7:6] == MOD_REG);
    fr    = i_modrm[5:3];
    fm    = i_modrm[2:0];
    add4  = xfd_mk(1'b0, 1'b0, PIPE_ADD, 1'b0, LK_FIX, LAT_SUB,
                   LAT_NONE, LAT_NONE);
    cmp2  = xfd_mk(1'b0, 1'b0, PIPE_ADD, 1'b0, LK_FIX, LAT_CMP,
                   LAT_NONE, LAT_NONE);
    e_nxt = ENT_NONE;
    case (i_opc0)
      OPC_D8:
        if ((fr == F_100) || (!rf && fr == F_101))
          e_nxt = add4;
      OPC_DC:
        // Register form 100 is not a subtract here, only 101
        if ((!rf && fr == F_100) || fr == F_101)
          e_nxt = add4;
      OPC_DE:
        if (rf && (fr == F_100 || fr == F_101))
          e_nxt = add4;
      OPC_DA:
        if (rf && fr == F_101 && fm == F_001)
          e_nxt = cmp2;
      OPC_DD:
        if (rf && (fr == F_100 || fr == F_101))
          e_nxt = cmp2;
      OPC_DB, OPC_DF:
        if (rf && fr == F_101)
          e_nxt = xfd_mk(1'b1, 1'b1, PIPE_ADD, 1'b0, LK_FIX, LAT_UCOMI,
                         LAT_NONE, LAT_NONE);
      OPC_9B:
        e_nxt = xfd_mk(1'b0, 1'b0, PIPE_NONE, 1'b0, LK_FIX, LAT_NONE,
                       LAT_NONE, LAT_NONE);
      OPC_0F:
        if (i_opc1 == OPC_AE && !rf && fr == F_001)
          e_nxt = xfd_mk(1'b1, 1'b0, PIPE_NONE, 1'b0, LK_PAIR, LAT_RST_LO,
                         LAT_RST_HI, LAT_NONE);
        else if (i_opc1 == OPC_AE && !rf && fr == F_000)
          e_nxt = xfd_mk(1'b1, 1'b0, PIPE_NONE, 1'b0, LK_PAIR, LAT_SAV_LO,
                         LAT_SAV_HI, LAT_NONE);
      OPC_D9:
        if (rf)
          case ({fr, fm})
            {F_100, F_100}: e_nxt = cmp2;
            {F_100, F_101}: e_nxt = xfd_mk(1'b1, 1'b0, PIPE_NONE, 1'b0,
                              LK_FIX, LAT_XAM, LAT_NONE, LAT_NONE);
            {F_110, F_100}: e_nxt = xfd_mk(1'b1, 1'b0, PIPE_NONE, 1'b0,
                              LK_FIX, LAT_XTRACT, LAT_NONE, LAT_NONE);
            {F_110, F_001}: e_nxt = xfd_mk(1'b1, 1'b0, PIPE_NONE, 1'b0,
                              LK_RNG, LAT_LOG_LO, LAT_LOG_HI,
                              LAT_NONE);
            {F_111, F_001}: e_nxt = xfd_mk(1'b1, 1'b0, PIPE_NONE, 1'b0,
                              LK_FIX, LAT_LOGP1, LAT_NONE, LAT_NONE);
            {F_111, F_000},
            {F_110, F_101}: e_nxt = xfd_mk(1'b0, 1'b0, PIPE_MUL, 1'b0,
                              LK_REM, LAT_REM, LAT_NONE, LAT_NONE);
            {F_111, F_010}: e_nxt = xfd_mk(1'b0, 1'b0, PIPE_MUL, 1'b0,
                              LK_PREC, LAT_SQRT_S, LAT_SQRT_D, LAT_SQRT_E);
            default:
              if (fr == F_001)
                e_nxt = xfd_mk(1'b0, 1'b0, PIPE_ANY, 1'b1, LK_FIX,
                               LAT_XCH, LAT_NONE, LAT_NONE);
          endcase
      default: e_nxt = ENT_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered entry
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      ent_if.ent <= ENT_NONE;
    else
      ent_if.ent <= e_nxt;
  end

endmodule : xfd_table

// File: design/xfd_decode.sv
// Floating-point decode classification and latency top module
`timescale 1ns/1ps
module xfd_decode
  import xfd_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_opc0,
  input  wire logic [7:0] i_opc1,
  input  wire logic [7:0] i_modrm,
  input  wire logic [1:0] i_prec_ctl,
  input  wire logic [7:0] i_exp_diff,
  input  wire logic [6:0] i_norm_shift,
  input  wire logic [2:0] i_pipe_free,
  output logic            o_valid,
  output logic            o_known,
  output logic            o_microcoded,
  output logic            o_single_op,
  output logic [2:0]      o_pipe_mask,
  output logic            o_nop_gen,
  output logic            o_best_case,
  output logic            o_reg_form,
  output logic            o_mem_form,
  output logic [2:0]      o_stack_idx,
  output logic [9:0]      o_lat_min,
  output logic [9:0]      o_lat_max,
  output logic [2:0]      o_nop_issue,
  output logic [7:0]      o_nop_lat
);

  xfd_ent_if   ent_if ();
  xfd_ent_type ent;

  logic       v1_r;
  logic [7:0] modrm1_r;
  logic [1:0] prec1_r;
  logic [7:0] exp1_r;
  logic [6:0] shift1_r;
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  logic [2:0] issue_nxt;
  logic [9:0] lmin_nxt;
  logic [9:0] lmax_nxt;

  assign ent = ent_if.ent;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] rem_lat(
    input logic [7:0] base,
    input logic [7:0] e,
    input logic [6:0] s
  );
    logic [7:0] n;
    n = 8'(({1'b0, s} + 8'h01) >> 1);
    if (n > REM_N_MAX)
      n = REM_N_MAX;
    return 10'(base) + 10'(e) + 10'(n);
  endfunction : rem_lat

  function automatic logic [7:0] prec_lat(
    input xfd_ent_type x,
    input logic [1:0]  pc
  );
    case (pc)
      PC_SINGLE: return x.lat_a;
      PC_DOUBLE: return x.lat_b;
      default:   return x.lat_c;
    endcase
  endfunction : prec_lat

  // ----------------------------------------------------------------
  // Table and first stage
  // ----------------------------------------------------------------
  xfd_table u_table (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_opc0    (i_opc0),
    .i_opc1    (i_opc1),
    .i_modrm   (i_modrm),
    .ent_if    (ent_if.src)
  );

  // Side data travels with the table so both land in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      v1_r     <= 1'b0;
      modrm1_r <= 8'h00;
      prec1_r  <= 2'h0;
      exp1_r   <= 8'h00;
      shift1_r <= 7'h00;
    end
    else
    begin
      v1_r     <= i_valid;
      modrm1_r <= i_modrm;
      prec1_r  <= i_prec_ctl;
      exp1_r   <= i_exp_diff;
      shift1_r <= i_norm_shift;
    end
  end

  // ----------------------------------------------------------------
  // Latency selection
  // ----------------------------------------------------------------
  always_comb
  begin
    lmin_nxt = 10'(ent.lat_a);
    lmax_nxt = 10'(ent.lat_a);
    case (ent.kind)
      LK_RNG, LK_PAIR: lmax_nxt = 10'(ent.lat_b);
      LK_PREC:
      begin
        lmin_nxt = 10'(prec_lat(ent, prec1_r));
        lmax_nxt = lmin_nxt;
      end
      LK_REM:
      begin
        lmin_nxt = rem_lat(ent.lat_a, exp1_r, shift1_r);
        lmax_nxt = lmin_nxt;
      end
      default:
      begin
        lmin_nxt = 10'(ent.lat_a);
        lmax_nxt = 10'(ent.lat_a);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Classification outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_valid      <= 1'b0;
      o_known      <= 1'b0;
      o_microcoded <= 1'b0;
      o_single_op  <= 1'b0;
      o_pipe_mask  <= PIPE_NONE;
      o_nop_gen    <= 1'b0;
      o_best_case  <= 1'b0;
      o_reg_form   <= 1'b0;
      o_mem_form   <= 1'b0;
      o_stack_idx  <= 3'h0;
      o_lat_min    <= 10'h000;
      o_lat_max    <= 10'h000;
    end
    else
    begin
      o_valid      <= v1_r;
      o_known      <= v1_r & ent.known;
      o_microcoded <= ent.micro;
      o_single_op  <= ent.single;
      o_pipe_mask  <= ent.pipes;
      o_nop_gen    <= v1_r & ent.nop_gen;
      o_best_case  <= ent.best;
      // Memory forms flag the consumer to add its load delay
      o_reg_form   <= (modrm1_r[7:6] == MOD_REG);
      o_mem_form   <= (modrm1_r[7:6] != MOD_REG);
      o_stack_idx  <= (modrm1_r[7:6] == MOD_REG) ? modrm1_r[2:0]
                                                 : 3'h0;
      o_lat_min    <= lmin_nxt;
      o_lat_max    <= lmax_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Internal no-op issue
  // ----------------------------------------------------------------
  // Counter saturates; no stall path, so a long busy spell can drop no-ops
  always_comb
  begin
    pend_nxt  = pend_r;
    issue_nxt = 3'h0;
    for (int i = 0; i < NUM_PIPES; i++)
    begin
      if (i_pipe_free[i] && pend_nxt != 4'h0)
      begin
        issue_nxt[i] = 1'b1;
        pend_nxt     = pend_nxt - 4'h1;
      end
    end
    if (v1_r && ent.nop_gen && pend_nxt != 4'hf)
      pend_nxt = pend_nxt + 4'h1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      pend_r      <= 4'h0;
      o_nop_issue <= 3'h0;
      o_nop_lat   <= LAT_NONE;
    end
    else
    begin
      pend_r      <= pend_nxt;
      o_nop_issue <= issue_nxt;
      o_nop_lat   <= LAT_NOP;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_stack_idx_src: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && o_reg_form |-> o_stack_idx == $past(i_modrm[2:0], 2))
    else $error("stack index not from modrm low bits");

  a_nop_free_pipe: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_nop_issue != 3'h0
    |-> (o_nop_issue & ~$past(i_pipe_free)) == 3'h0 && o_nop_lat == LAT_NOP)
    else $error("no-op issued to busy pipe or wrong latency");

  a_single_op_pipe: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && o_single_op |-> o_microcoded && $onehot(o_pipe_mask))
    else $error("single operation not on exactly one pipe");

  a_prec_sqrt_lat: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && $past(i_opc0, 2) == OPC_D9 && $past(i_modrm, 2) == 8'hfa
    |-> o_lat_min == (($past(i_prec_ctl, 2) == PC_SINGLE) ? 10'd19 :
                      ($past(i_prec_ctl, 2) == PC_DOUBLE) ? 10'd27 : 10'd35))
    else $error("precision latency wrong");

  a_rem_lat_sum: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && $past(i_opc0, 2) == OPC_D9 && $past(i_modrm, 2) == 8'hf8
    |-> o_lat_min == rem_lat(LAT_REM, $past(i_exp_diff, 2),
                             $past(i_norm_shift, 2)) && o_lat_min <= 10'd296)
    else $error("remainder latency wrong");

  a_sub_mem_dc: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && $past(i_opc0, 2) == OPC_DC && $past(i_modrm[5:3], 2) == F_100
    && o_mem_form |-> !o_microcoded && o_pipe_mask == PIPE_ADD
    && o_lat_min == 10'd4)
    else $error("memory subtract decode wrong");

  a_ucomi_decode: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && o_reg_form && $past(i_modrm[5:3], 2) == F_101
    && ($past(i_opc0, 2) == OPC_DB || $past(i_opc0, 2) == OPC_DF)
    |-> o_microcoded && o_single_op && o_pipe_mask == PIPE_ADD
    && o_lat_max == 10'd3)
    else $error("unordered compare decode wrong");

  a_xrstor_lat: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && o_mem_form && $past(i_opc0, 2) == OPC_0F
    && $past(i_opc1, 2) == OPC_AE && $past(i_modrm[5:3], 2) == F_001
    |-> o_microcoded && o_lat_min == 10'd68 && o_lat_max == 10'd108)
    else $error("state restore decode wrong");

  a_xch_nop: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && o_nop_gen |-> o_pipe_mask == PIPE_ANY && o_lat_min == 10'd2
    ##1 (o_nop_issue != 3'h0 || $past(i_pipe_free) == 3'h0))
    else $error("exchange decode or no-op issue wrong");

  a_log_range: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid && $past(i_opc0, 2) == OPC_D9 && $past(i_modrm, 2) == 8'hf1
    |-> o_microcoded && o_lat_min == 10'd116 && o_lat_max == 10'd126)
    else $error("log product latency wrong");

  a_form_split: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    o_valid |-> o_reg_form == ($past(i_modrm[7:6], 2) == MOD_REG)
    && o_mem_form == !o_reg_form)
    else $error("register/memory form split wrong");

endmodule : xfd_decode

// File: verif/xfd_pipe_model.sv
// Floating-point pipe model facing the decode block
`timescale 1ns/1ps
module xfd_pipe_model
  import xfd_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic [2:0] i_busy,
  input  wire logic       i_valid,
  input  wire logic       i_mem_form,
  input  wire logic [9:0] i_lat_min,
  output logic      [2:0] o_pipe_free,
  output logic      [9:0] o_use_lat
);
  // ----------------------------------------------------------------
  // Pipe occupancy
  // ----------------------------------------------------------------
  // Free mask lags busy by one edge, as a real pipe would
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_pipe_free <= 3'h0;
    else
      o_pipe_free <= ~i_busy;
  end

  // ----------------------------------------------------------------
  // Consumer scheduling
  // ----------------------------------------------------------------
  // Load/store time is not in the figure, so memory forms wait longer
  always_comb
  begin
    if (!i_valid)
      o_use_lat = 10'h000;
    else if (i_mem_form)
      o_use_lat = i_lat_min + 10'h002;
    else
      o_use_lat = i_lat_min;
  end
endmodule : xfd_pipe_model

// File: verif/xfd_decode_tb.sv
// Self-checking bench for the floating-point decode block
`timescale 1ns/1ps
module xfd_decode_tb;
  import xfd_pkg::*;
  logic       i_clk_sys;
  logic       i_sys_rst;
  logic       i_valid;
  logic [7:0] i_opc0;
  logic [7:0] i_opc1;
  logic [7:0] i_modrm;
  logic [1:0] i_prec_ctl;
  logic [7:0] i_exp_diff;
  logic [6:0] i_norm_shift;
  logic [2:0] i_pipe_free;
  logic [2:0] busy;
  logic       o_valid, o_known, o_microcoded, o_single_op;
  logic       o_nop_gen, o_best_case, o_reg_form, o_mem_form;
  logic [2:0] o_pipe_mask, o_stack_idx, o_nop_issue;
  logic [9:0] o_lat_min, o_lat_max, use_lat;
  logic [7:0] o_nop_lat;
  int         num_errors;
  int         total_checks;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  xfd_decode u_dut (.i_clk_sys, .i_sys_rst, .i_valid, .i_opc0, .i_opc1,
    .i_modrm, .i_prec_ctl, .i_exp_diff, .i_norm_shift, .i_pipe_free,
    .o_valid, .o_known, .o_microcoded, .o_single_op, .o_pipe_mask,
    .o_nop_gen, .o_best_case, .o_reg_form, .o_mem_form, .o_stack_idx,
    .o_lat_min, .o_lat_max, .o_nop_issue, .o_nop_lat);

  xfd_pipe_model u_pipes (.i_clk_sys, .i_sys_rst, .i_busy(busy),
    .i_valid(o_valid), .i_mem_form(o_mem_form), .i_lat_min(o_lat_min),
    .o_pipe_free(i_pipe_free), .o_use_lat(use_lat));

  initial i_clk_sys = 1'b0;
  always #20 i_clk_sys = ~i_clk_sys;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic put(input logic [7:0] b0, input logic [7:0] b1,
                     input logic [7:0] m, input logic [1:0] p,
                     input logic [7:0] e, input logic [6:0] s);
    @(posedge i_clk_sys);
    i_valid      <= 1'b1;
    i_opc0       <= b0;
    i_opc1       <= b1;
    i_modrm      <= m;
    i_prec_ctl   <= p;
    i_exp_diff   <= e;
    i_norm_shift <= s;
  endtask : put

  // Result lands one edge after the taking edge
  task automatic idle_res;
    @(posedge i_clk_sys);
    i_valid <= 1'b0;
    @(posedge i_clk_sys);
    #1;
  endtask : idle_res

  task automatic run(input logic [7:0] b0, input logic [7:0] m);
    put(b0, 8'h00, m, 2'h3, 8'h00, 7'h00);
    idle_res();
  endtask : run

  task automatic ent(input logic mi, input logic so, input logic [2:0] pm,
                     input logic ng, input logic [9:0] lo,
                     input logic [9:0] hi);
    chk({9'h000, o_valid}, 10'h001);
    chk({9'h000, o_known}, 10'h001);
    chk({9'h000, o_microcoded}, {9'h000, mi});
    chk({9'h000, o_single_op}, {9'h000, so});
    chk({7'h00, o_pipe_mask}, {7'h00, pm});
    chk({9'h000, o_nop_gen}, {9'h000, ng});
    chk({9'h000, o_best_case}, 10'h000);
    chk(o_lat_min, lo);
    chk(o_lat_max, hi);
  endtask : ent

  task automatic wait_nop;
    int i;
    for (i = 0; i < 12 && o_nop_issue === 3'h0; i++)
    begin
      @(posedge i_clk_sys);
      #1;
    end
    if (o_nop_issue === 3'h0)
    begin
      num_errors++;
      $display("BAD %0t no-op never issued", $time);
      complete_run();
    end
  endtask : wait_nop

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sub;
    logic [1:0] md;
    for (int k = 0; k < 3; k++)
    begin
      md = k[1:0];
      run(8'hdc, {md, 6'h26});
      ent(1'b0, 1'b0, 3'h1, 1'b0, 10'h004, 10'h004);
      chk({9'h000, o_mem_form}, 10'h001);
      chk({7'h00, o_stack_idx}, 10'h000);
      chk(use_lat, 10'h006);
    end
    run(8'hd8, 8'he5);
    ent(1'b0, 1'b0, 3'h1, 1'b0, 10'h004, 10'h004);
    chk({9'h000, o_reg_form}, 10'h001);
    chk({7'h00, o_stack_idx}, 10'h005);
  endtask : t_sub

  task automatic t_ucom;
    run(8'hdb, 8'hea);
    ent(1'b1, 1'b1, 3'h1, 1'b0, 10'h003, 10'h003);
    run(8'hdf, 8'hef);
    ent(1'b1, 1'b1, 3'h1, 1'b0, 10'h003, 10'h003);
    chk({7'h00, o_stack_idx}, 10'h007);
  endtask : t_ucom

  task automatic t_state;
    put(8'h0f, 8'hae, 8'h08, 2'h3, 8'h00, 7'h00);
    idle_res();
    ent(1'b1, 1'b0, 3'h0, 1'b0, 10'h044, 10'h06c);
    put(8'h0f, 8'hae, 8'h40, 2'h3, 8'h00, 7'h00);
    idle_res();
    ent(1'b1, 1'b0, 3'h0, 1'b0, 10'h01f, 10'h04f);
    run(8'hd9, 8'hf1);
    ent(1'b1, 1'b0, 3'h0, 1'b0, 10'h074, 10'h07e);
  endtask : t_state

  task automatic t_prec;
    logic [9:0] want [4] = '{10'h013, 10'h023, 10'h01b, 10'h023};
    for (int p = 0; p < 4; p++)
    begin
      put(8'hd9, 8'h00, 8'hfa, p[1:0], 8'h00, 7'h00);
      idle_res();
      ent(1'b0, 1'b0, 3'h2, 1'b0, want[p], want[p]);
    end
  endtask : t_prec

  task automatic t_rem;
    logic [7:0] ev [4] = '{8'h00, 8'h05, 8'h03, 8'hff};
    logic [6:0] sv [4] = '{7'h00, 7'h09, 7'h3f, 7'h7f};
    logic [9:0] lv [4] = '{10'h009, 10'h013, 10'h02c, 10'h128};
    for (int k = 0; k < 4; k++)
    begin
      put(8'hd9, 8'h00, 8'hf8, 2'h3, ev[k], sv[k]);
      idle_res();
      ent(1'b0, 1'b0, 3'h2, 1'b0, lv[k], lv[k]);
    end
  endtask : t_rem

  // Three exchanges back to back while every pipe is busy
  task automatic t_xch;
    busy <= 3'h7;
    repeat (3) put(8'hd9, 8'h00, 8'hcb, 2'h3, 8'h00, 7'h00);
    idle_res();
    ent(1'b0, 1'b0, 3'h7, 1'b1, 10'h002, 10'h002);
    repeat (4) @(posedge i_clk_sys);
    #1;
    chk({7'h00, o_nop_issue}, 10'h000);
    busy <= 3'h0;
    wait_nop();
    chk({7'h00, o_nop_issue}, 10'h007);
    chk({2'h0, o_nop_lat}, 10'h002);
    @(posedge i_clk_sys);
    #1;
    chk({7'h00, o_nop_issue}, 10'h000);
    busy <= 3'h6;
    run(8'hd9, 8'hc8);
    wait_nop();
    chk({7'h00, o_nop_issue}, 10'h001);
    busy <= 3'h0;
  endtask : t_xch

  task automatic t_misc;
    run(8'h00, 8'hc0);
    chk({9'h000, o_valid}, 10'h001);
    chk({9'h000, o_known}, 10'h000);
    chk(o_lat_min, 10'h000);
    run(8'hdc, 8'he0);
    chk({9'h000, o_known}, 10'h000);
    chk({7'h00, o_stack_idx}, 10'h000);
    run(8'h9b, 8'hff);
    ent(1'b0, 1'b0, 3'h0, 1'b0, 10'h000, 10'h000);
  endtask : t_misc

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    num_errors   = 0;
    total_checks = 0;
    i_sys_rst    = 1'b1;
    i_valid      = 1'b0;
    i_opc0       = 8'h00;
    i_opc1       = 8'h00;
    i_modrm      = 8'h00;
    i_prec_ctl   = 2'h0;
    i_exp_diff   = 8'h00;
    i_norm_shift = 7'h00;
    busy         = 3'h0;
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    chk({9'h000, o_valid}, 10'h000);
    t_sub();
    t_ucom();
    t_state();
    t_prec();
    t_rem();
    t_xch();
    t_misc();
    complete_run();
  end
endmodule : xfd_decode_tb
